// file: srp_pkg.sv
`default_nettype none
package srp_pkg;
    // Register space
    localparam int          SRP_ADDR_W          = 5;
    localparam int          SRP_NUM_REGS        = 32;
    localparam int          SRP_DATA_W          = 8;
    localparam logic [4:0]  SRP_ADDR_CONFIG     = 5'h00;
    localparam logic [4:0]  SRP_ADDR_I_OFFSET   = 5'h08;
    localparam logic [4:0]  SRP_ADDR_Q_OFFSET   = 5'h0C;
    localparam logic [7:0]  SRP_REG_RESET_VALUE = 8'h00;

    // Field positions in serial_port_config and the offset registers
    localparam int          SRP_CFG_BIDIR_BIT   = 7;
    localparam int          SRP_CFG_LSB_BIT     = 6;
    localparam int          SRP_CFG_SRST_BIT    = 5;
    localparam int          SRP_OFFSET_DIR_BIT  = 7;

    // Field positions in the instruction byte
    localparam int          SRP_INSTR_RW_BIT    = 7;
    localparam int          SRP_INSTR_CNT_HI    = 6;
    localparam int          SRP_INSTR_CNT_LO    = 5;

    // Serial timing
    localparam logic [2:0]  SRP_LAST_BIT        = 3'h7;
    localparam int          SRP_SCLK_MAX_MHZ    = 15;
    localparam int          SRP_SYS_MHZ         = 20;

    // Sequencer states, Gray coded along instruction -> data -> done
    typedef enum logic [1:0] {
        SRP_ST_INSTR = 2'b00,
        SRP_ST_DATA  = 2'b01,
        SRP_ST_DONE  = 2'b11
    } srp_state_e;
endpackage
`default_nettype wire

// file: srp_pin_if.sv
`timescale 1ns/1ns
`default_nettype none
// Synchronised view of the serial pins, shared by the front end and the sequencer
interface srp_pin_if;
    logic sclk_rise;   // One-cycle pulse on a serial clock rising edge
    logic sclk_fall;   // One-cycle pulse on a serial clock falling edge
    logic sdio_in;     // Synchronised data-in level
    logic sel_n;       // Synchronised chip select, active low
    modport front (output sclk_rise, output sclk_fall, output sdio_in, output sel_n);
    modport seq   (input sclk_rise, input sclk_fall, input sdio_in, input sel_n);
endinterface
`default_nettype wire

// file: srp_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Two-flop synchronisers for chip select and data, three flops for the serial clock, plus serial clock edge detection
module srp_pin_sync (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic spi_clk,
    input  wire logic port_select_n,
    input  wire logic sdio_pin,
    srp_pin_if.front  pins
);
    import srp_pkg::*;

    logic [1:0] clk_meta;    // First two stages; only the third stage reads them
    logic [1:0] clk_sync;    // Third stage and one history stage
    logic [1:0] sel_meta;    // Chip select synchroniser
    logic [1:0] din_meta;    // Data synchroniser

    // Synchronisers; chip select idles high so the port starts deselected
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            clk_meta <= 2'h0;
            clk_sync <= 2'h0;
            sel_meta <= 2'h3;
            din_meta <= 2'h0;
        end else begin
            clk_meta <= {clk_meta[0], spi_clk};
            clk_sync <= {clk_sync[0], clk_meta[1]};
            sel_meta <= {sel_meta[0], port_select_n};
            din_meta <= {din_meta[0], sdio_pin};
        end
    end

    // Edges are seen only on stages past the first flop; data is taken one
    // stage earlier than the edge, still well inside its stable window
    assign pins.sclk_rise = clk_sync[0] & ~clk_sync[1];
    assign pins.sclk_fall = ~clk_sync[0] & clk_sync[1];
    assign pins.sdio_in   = din_meta[1];
    assign pins.sel_n     = sel_meta[1];
endmodule
`default_nettype wire

// file: srp_port.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - First eight rising edges carry the instruction.
// - Chip select high restarts, discards partial bytes.
// - Data phase moves one to four bytes.
// - Register updates on its byte's last bit.
// - Instruction bit 7 high means read.
// - Bits 6:5 give byte count minus one.
// - Bits 4:0 give start address.
// - Sample on rise, launch read data on fall.
// - Chip select high floats both data outputs.
// - Config bit 7 makes data pin bidirectional.
// - Bidirectional mode keeps separate output floating.
// - LSB-first order, address increments per byte.
// - MSB-first order default, address decrements.
// - Address wraps between 1Fh and 00h.
// - Config changes apply within the same cycle.
// - Software reset clears all but config register.
// - Mirrored config byte recovers lost bit order.
// - Offset direction bits of 08h and 0Ch.
module srp_port (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic spi_clk,
    input  wire logic port_select_n,
    input  wire logic sdio_in,
    output logic      sdio_out,
    output logic      sdio_oe_n,
    output logic      serial_data_out,
    output logic      serial_data_out_oe_n,
    output logic      in_phase_offset_to_b,
    output logic      quadrature_offset_to_b,
    output logic [srp_pkg::SRP_DATA_W-1:0] config_value
);
    import srp_pkg::*;

    srp_pin_if pins ();

    // Pin front end
    srp_pin_sync u_sync (
        .clk_sys       (clk_sys),
        .reset         (reset),
        .spi_clk       (spi_clk),
        .port_select_n (port_select_n),
        .sdio_pin      (sdio_in),
        .pins          (pins)
    );

    logic [7:0]            regs [SRP_NUM_REGS];  // Configuration register space
    srp_state_e            state;                // Sequencer phase
    logic [2:0]            bit_cnt;              // Bits taken in the current byte
    logic [7:0]            shift_in;             // Partial byte being received
    logic [7:0]            next_byte;            // Byte as it stands after this edge
    logic                  read_mode;            // Data phase direction
    logic [1:0]            bytes_left;           // Data bytes after the current one
    logic [SRP_ADDR_W-1:0] addr;                 // Internal byte address
    logic                  out_bit;              // Launched read bit
    logic                  active;               // Selected and edge-driven
    logic                  byte_done;            // Last bit of a byte this edge
    logic                  data_wr;              // Write completes this edge
    logic                  cfg_wr;               // Write hits the config register
    logic                  srst;                 // Software reset request
    logic                  lsb_now;              // Bit order valid after this edge
    logic                  bidir;                // Single pin mode
    logic                  lsb_first;            // Bit order control

    assign bidir     = regs[SRP_ADDR_CONFIG][SRP_CFG_BIDIR_BIT];
    assign lsb_first = regs[SRP_ADDR_CONFIG][SRP_CFG_LSB_BIT];
    assign active    = ~pins.sel_n & pins.sclk_rise;
    assign byte_done = active & (bit_cnt == SRP_LAST_BIT);

    // Assemble the byte in the current order; a mid-cycle config write
    // has already landed in regs, so the next byte follows it
    always_comb begin
        if (lsb_first) begin
            next_byte = {pins.sdio_in, shift_in[7:1]};
        end else begin
            next_byte = {shift_in[6:0], pins.sdio_in};
        end
    end

    assign data_wr = byte_done & (state == SRP_ST_DATA) & ~read_mode;
    assign cfg_wr  = data_wr & (addr == SRP_ADDR_CONFIG);
    // A bit-reversal palindrome reads the same in either order, so a host
    // that lost track of bit order still lands its reset and configuration
    assign srst    = cfg_wr & next_byte[SRP_CFG_SRST_BIT];
    // The address step after a config write already uses the new order
    assign lsb_now = cfg_wr ? next_byte[SRP_CFG_LSB_BIT] : lsb_first;

    // Phase sequencer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= SRP_ST_INSTR;
        end else if (pins.sel_n) begin
            // Deselect drops whatever was in flight
            state <= SRP_ST_INSTR;
        end else if (byte_done) begin
            case (state)
                SRP_ST_INSTR: begin
                    state <= SRP_ST_DATA;
                end
                SRP_ST_DATA: begin
                    if (bytes_left == 2'h0) begin
                        state <= SRP_ST_DONE;
                    end
                end
                SRP_ST_DONE: begin
                    state <= SRP_ST_DONE;
                end
                default: begin
                    state <= SRP_ST_INSTR;
                end
            endcase
        end
    end

    // Bit counter and input shifter, sampled on rising edges
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bit_cnt  <= 3'h0;
            shift_in <= 8'h00;
        end else if (pins.sel_n) begin
            bit_cnt  <= 3'h0;
            shift_in <= 8'h00;
        end else if (active && state != SRP_ST_DONE) begin
            bit_cnt  <= bit_cnt + 3'h1;
            shift_in <= next_byte;
        end
    end

    // Instruction capture and address generation
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            read_mode  <= 1'b0;
            bytes_left <= 2'h0;
            addr       <= 5'h00;
        end else if (byte_done) begin
            if (state == SRP_ST_INSTR) begin
                read_mode  <= next_byte[SRP_INSTR_RW_BIT];
                bytes_left <= next_byte[SRP_INSTR_CNT_HI:SRP_INSTR_CNT_LO];
                addr       <= next_byte[SRP_ADDR_W-1:0];
            end else if (state == SRP_ST_DATA) begin
                bytes_left <= bytes_left - 2'h1;
                // 5-bit arithmetic wraps 1Fh<->00h on its own
                if (lsb_now) begin
                    addr <= addr + 5'h01;
                end else begin
                    addr <= addr - 5'h01;
                end
            end
        end
    end

    // Register space; each byte lands on its own last bit, not at deselect
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < SRP_NUM_REGS; i++) begin
                regs[i] <= SRP_REG_RESET_VALUE;
            end
        end else if (data_wr) begin
            if (srst) begin
                // Config register keeps the written byte, all others default
                for (int i = 1; i < SRP_NUM_REGS; i++) begin
                    regs[i] <= SRP_REG_RESET_VALUE;
                end
            end
            regs[addr] <= next_byte;
        end
    end

    // Read data launch on falling edges in the chosen order
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_bit <= 1'b0;
        end else if (pins.sclk_fall && !pins.sel_n && state == SRP_ST_DATA && read_mode) begin
            if (lsb_first) begin
                out_bit <= regs[addr][bit_cnt];
            end else begin
                out_bit <= regs[addr][3'h7 - bit_cnt];
            end
        end
    end

    // Output drivers; enables are active low and float outside read data
    always_comb begin
        sdio_out             = out_bit;
        serial_data_out      = out_bit;
        sdio_oe_n            = 1'b1;
        serial_data_out_oe_n = 1'b1;
        if (!pins.sel_n && read_mode && state == SRP_ST_DATA) begin
            if (bidir) begin
                sdio_oe_n = 1'b0;
            end else begin
                serial_data_out_oe_n = 1'b0;
            end
        end
    end

    // Offset steering to the analog side and live config view
    assign in_phase_offset_to_b   = regs[SRP_ADDR_I_OFFSET][SRP_OFFSET_DIR_BIT];
    assign quadrature_offset_to_b = regs[SRP_ADDR_Q_OFFSET][SRP_OFFSET_DIR_BIT];
    assign config_value           = regs[SRP_ADDR_CONFIG];

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_restart;
        pins.sel_n |=> (state == SRP_ST_INSTR) && (bit_cnt == 3'h0);
    endproperty
    a_restart: assert property (p_restart) else $error("deselect did not restart");

    property p_instr;
        (byte_done && state == SRP_ST_INSTR) |=>
            state == SRP_ST_DATA && read_mode == $past(next_byte[7]) &&
            addr == $past(next_byte[4:0]);
    endproperty
    a_instr: assert property (p_instr) else $error("instruction not captured");

    property p_count;
        (byte_done && state == SRP_ST_INSTR) |=> bytes_left == $past(next_byte[6:5]);
    endproperty
    a_count: assert property (p_count) else $error("byte count wrong");

    property p_write_now;
        (data_wr && addr != 5'h00) |=> regs[$past(addr)] == $past(next_byte);
    endproperty
    a_write_now: assert property (p_write_now) else $error("write not immediate");

    property p_addr_step;
        (byte_done && state == SRP_ST_DATA && !cfg_wr) |=>
            addr == (lsb_first ? $past(addr) + 5'h01 : $past(addr) - 5'h01);
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address step wrong");

    property p_float;
        pins.sel_n |-> sdio_oe_n && serial_data_out_oe_n;
    endproperty
    a_float: assert property (p_float) else $error("output driven while deselected");

    property p_bidir;
        bidir |-> serial_data_out_oe_n;
    endproperty
    a_bidir: assert property (p_bidir) else $error("separate output driven in bidir");

    property p_done_quiet;
        (state == SRP_ST_DONE && !pins.sel_n) |=> $stable(bit_cnt) && !data_wr;
    endproperty
    a_done_quiet: assert property (p_done_quiet) else $error("edges used after last byte");

    property p_srst;
        srst |=> regs[1] == SRP_REG_RESET_VALUE && regs[0] == $past(next_byte);
    endproperty
    a_srst: assert property (p_srst) else $error("software reset wrong");

    property p_launch;
        $changed(out_bit) |-> $past(pins.sclk_fall);
    endproperty
    a_launch: assert property (p_launch) else $error("read bit not on falling edge");

    // The last counted byte closes the data phase
    property p_last_byte;
        (byte_done && state == SRP_ST_DATA && bytes_left == 2'h0) |=> state == SRP_ST_DONE;
    endproperty
    a_last_byte: assert property (p_last_byte) else $error("data phase did not end");

    // Earlier bytes keep the data phase open and use up one count each
    property p_more_bytes;
        (byte_done && state == SRP_ST_DATA && bytes_left != 2'h0) |=>
            state == SRP_ST_DATA && bytes_left == $past(bytes_left) - 2'h1;
    endproperty
    a_more_bytes: assert property (p_more_bytes) else $error("byte count not stepped");

    // The bit counter starts the data phase clean after the instruction
    property p_instr_wrap;
        (byte_done && state == SRP_ST_INSTR) |=> bit_cnt == 3'h0;
    endproperty
    a_instr_wrap: assert property (p_instr_wrap) else $error("bit count not restarted");

    // A config write is live on the very next edge, mid-cycle included
    property p_cfg_live;
        cfg_wr |=> bidir == $past(next_byte[SRP_CFG_BIDIR_BIT]) &&
            lsb_first == $past(next_byte[SRP_CFG_LSB_BIT]);
    endproperty
    a_cfg_live: assert property (p_cfg_live) else $error("config not applied at once");

    // In a read data phase exactly the pin chosen by config bit 7 drives
    property p_pin_select;
        (!pins.sel_n && state == SRP_ST_DATA && read_mode) |->
            (sdio_oe_n != bidir) && (serial_data_out_oe_n == bidir);
    endproperty
    a_pin_select: assert property (p_pin_select) else $error("wrong read pin driven");

    // Writes and the instruction phase never turn a driver on
    property p_write_quiet;
        (state != SRP_ST_DATA || !read_mode) |-> sdio_oe_n && serial_data_out_oe_n;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("driver on outside read");

    // Software reset reaches the top of the register space as well
    property p_srst_top;
        srst |=> regs[SRP_NUM_REGS-1] == SRP_REG_RESET_VALUE;
    endproperty
    a_srst_top: assert property (p_srst_top) else $error("top register not reset");
endmodule
`default_nettype wire

// file: srp_host.sv
`timescale 1ns/1ns
`default_nettype none
// Behavioural serial master standing in for the host processor
module srp_host (
    input  wire logic  clk_sys,
    input  wire logic  sdio_line,
    input  wire logic  serial_data_out,
    input  wire logic  sdio_oe_n,
    input  wire logic  serial_data_out_oe_n,
    output logic       spi_clk,
    output logic       port_select_n,
    output logic       sdio_host
);
    // Idle: deselected, serial clock parked low
    initial begin
        spi_clk       = 1'b0;
        port_select_n = 1'b1;
        sdio_host     = 1'b0;
    end

    // Half a 400 ns serial period, far below the top serial rate
    task automatic half();
        repeat (4) @(negedge clk_sys);
    endtask

    // One cycle: instruction byte first, then data bytes, order per byte from lsbm
    task automatic run(input logic [39:0] frame, input logic [4:0] lsbm, input int nbits,
                       input logic rd_op, input logic bidir, output logic [31:0] rd,
                       output logic [1:0] oe);
        int  k;
        int  j;
        logic rel;
        rd = '0;
        oe = 2'b11;
        @(negedge clk_sys);
        port_select_n = 1'b0;
        half();
        for (int b = 0; b < nbits; b++) begin
            k = b / 8;
            j = lsbm[k] ? b % 8 : 7 - b % 8;
            rel = rd_op && k > 0;
            // Released line shows a toggling pattern, never a stale value
            sdio_host = rel ? ~sdio_host : frame[8*k+j];
            spi_clk = 1'b0;
            half();
            // Read bit is taken just before the rising edge: after the last rise
            // the device leaves the data phase and floats its driver again
            if (rel) begin
                rd[8*(k-1)+j] = bidir ? sdio_line : serial_data_out;
                oe = {sdio_oe_n, serial_data_out_oe_n};
            end
            spi_clk = 1'b1;
            half();
        end
        spi_clk = 1'b0;
        half();
        port_select_n = 1'b1;
        repeat (8) @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench: host model drives cycles, a register model predicts results
module tb;
    import srp_pkg::*;
    logic        clk_sys;        // 20 MHz system clock
    logic        reset;          // Synchronous, active high
    logic        spi_clk;        // From host model
    logic        port_select_n;  // From host model
    logic        sdio_host;      // Host side of the data pin
    logic        sdio_line;      // Resolved data pin level
    logic        sdio_out;
    logic        sdio_oe_n;
    logic        serial_data_out;
    logic        serial_data_out_oe_n;
    logic        in_phase_offset_to_b;
    logic        quadrature_offset_to_b;
    logic [7:0]  config_value;
    logic [7:0]  regs [32];      // Register model
    logic [31:0] seed = 32'h5C976EE0;
    logic [31:0] d32;
    logic [4:0]  a5;
    int          n_errors = 0;
    int          compares = 0;
    int          cycles = 0;

    // Device wins the pin only while it enables its driver
    assign sdio_line = !sdio_oe_n ? sdio_out : sdio_host;

    srp_port srp_port_inst (.clk_sys(clk_sys), .reset(reset), .spi_clk(spi_clk),
        .port_select_n(port_select_n), .sdio_in(sdio_line), .sdio_out(sdio_out),
        .sdio_oe_n(sdio_oe_n), .serial_data_out(serial_data_out),
        .serial_data_out_oe_n(serial_data_out_oe_n),
        .in_phase_offset_to_b(in_phase_offset_to_b),
        .quadrature_offset_to_b(quadrature_offset_to_b), .config_value(config_value));

    srp_host host_inst (.clk_sys(clk_sys), .sdio_line(sdio_line),
        .serial_data_out(serial_data_out), .sdio_oe_n(sdio_oe_n),
        .serial_data_out_oe_n(serial_data_out_oe_n), .spi_clk(spi_clk),
        .port_select_n(port_select_n), .sdio_host(sdio_host));

    // Clock generator
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Xorshift source for addresses and data
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic end_sim();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Levels that must follow the model between cycles
    task automatic state();
        check("config_value", config_value, regs[0]);
        check("offset_i", in_phase_offset_to_b, regs[8][7]);
        check("offset_q", quadrature_offset_to_b, regs[12][7]);
        check("idle_oe", {sdio_oe_n, serial_data_out_oe_n}, 2'b11);
    endtask

    // One cycle: model predicts, host runs it, results compared; cut>0 aborts early
    task automatic xfer(input logic [7:0] ins, input logic [31:0] d, input int nb,
                        input int cut, input logic flip);
        int          a;
        int          cnt;
        int          nbits;
        logic [4:0]  m;
        logic [31:0] rd;
        logic [1:0]  oe;
        logic [7:0]  ex [4];
        logic        bidir;
        m = '0;
        a = int'(ins[4:0]);
        cnt = int'(ins[6:5]) + 1;
        bidir = regs[0][SRP_CFG_BIDIR_BIT];
        nbits = (cut > 0) ? cut : 8 * (nb + 1);
        m[0] = regs[0][SRP_CFG_LSB_BIT];
        for (int k = 0; k < nb; k++) begin
            m[k+1] = regs[0][SRP_CFG_LSB_BIT];
            // Only whole counted bytes take effect; extra edges are ignored
            if (k < cnt && (k + 2) * 8 <= nbits) begin
                ex[k] = regs[a];
                if (!ins[7]) begin
                    regs[a] = d[8*k +: 8];
                    if (a == 0 && regs[0][SRP_CFG_SRST_BIT]) begin
                        for (int r = 1; r < 32; r++) regs[r] = SRP_REG_RESET_VALUE;
                    end
                end
                // New order already steers this byte's address step
                a = regs[0][SRP_CFG_LSB_BIT] ? (a + 1) % 32 : (a + 31) % 32;
            end
        end
        host_inst.run({d, ins}, m ^ {5{flip}}, nbits, ins[7], bidir, rd, oe);
        if (ins[7] && cut == 0) begin
            for (int k = 0; k < cnt; k++) check("read_byte", rd[8*k +: 8], ex[k]);
            check("read_oe", oe, bidir ? 2'b01 : 2'b10);
        end
        state();
    endtask

    // Hang guard, about five times the expected run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            end_sim();
        end
    end

    // Main sequence
    initial begin
        reset = 1'b1;
        for (int r = 0; r < 32; r++) regs[r] = SRP_REG_RESET_VALUE;
        repeat (16) @(negedge clk_sys);
        reset = 1'b0;
        repeat (4) @(negedge clk_sys);
        state();
        xfer(8'h08, 32'h80, 1, 0, 1'b0);
        // Every count code, write then read back, MSB first decrementing
        for (int i = 0; i < 8; i++) begin
            a5 = 5'(4 + rnd() % 28);
            d32 = rnd();
            xfer({1'b0, 2'(i), a5}, d32, i % 4 + 1, 0, 1'b0);
            xfer({1'b1, 2'(i), a5}, 32'h0, i % 4 + 1, 0, 1'b0);
        end
        xfer(8'hE1, 32'h0, 4, 0, 1'b0);
        xfer(8'h10, 32'hA5C3, 2, 0, 1'b0);
        xfer(8'hB0, 32'h0, 2, 0, 1'b0);
        xfer(8'h2C, 32'hFFFF, 2, 20, 1'b0);
        xfer(8'h08, 32'h00, 1, 5, 1'b0);
        xfer(8'hCC, 32'h0, 3, 0, 1'b0);
        xfer(8'h00, 32'h80, 1, 0, 1'b0);
        xfer(8'hF4, 32'h0, 4, 0, 1'b0);
        xfer(8'h20, 32'h5AC0, 2, 0, 1'b0);
        xfer(8'hE0, 32'h0, 4, 0, 1'b0);
        // Mirrored configuration written in the wrong bit order still lands
        for (int j = 0; j < 2; j++) begin
            xfer(8'h0C, 32'h80 | rnd() % 128, 1, 0, 1'b0);
            xfer(8'h00, (j == 0) ? 32'h66 : 32'hA5, 1, 0, 1'b1);
            xfer(8'hEC, 32'h0, 4, 0, 1'b0);
        end
        xfer(8'h00, 32'h00, 1, 0, 1'b0);
        xfer(8'hE6, 32'h0, 4, 0, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
